/* verilog/dcf_pkg.sv */
`default_nettype none
// shared constants of the debug comparator and trace readout block
package dcf_pkg;
   // register byte addresses on the cpu bus
   localparam logic [15:0] DCF_ADDR_CBL = 16'h3013;
   localparam logic [15:0] DCF_ADDR_CCH = 16'h3014;
   localparam logic [15:0] DCF_ADDR_CCL = 16'h3015;
   localparam logic [15:0] DCF_ADDR_FH = 16'h3016;
   localparam logic [15:0] DCF_ADDR_FL = 16'h3017;
   localparam logic [15:0] DCF_ADDR_CAX = 16'h3018;
   // reset values
   localparam logic [7:0] DCF_RST_CBL = 8'h00;
   localparam logic [7:0] DCF_RST_CCH = 8'h00;
   localparam logic [7:0] DCF_RST_CCL = 8'h00;
   localparam logic [7:0] DCF_RST_CAX = 8'h00;
   localparam logic [15:0] DCF_RST_WORD = 16'h0000;
   localparam logic [7:0] DCF_RDATA_IDLE = 8'h00;
   // comparator a extension fields
   localparam int DCF_CAX_QUAL_BIT = 7;
   localparam int DCF_CAX_VAL_BIT = 6;
   // trace fifo shape
   localparam int DCF_FIFO_DEPTH = 8;
   localparam int DCF_PTR_W = 3;
   localparam int DCF_CNT_W = 4;
   localparam logic [DCF_CNT_W-1:0] DCF_FIFO_FULL_CNT = 4'h8;
   // comparator indices
   localparam int DCF_CMP_A = 0;
   localparam int DCF_CMP_B = 1;
   localparam int DCF_CMP_C = 2;
   localparam int DCF_NUM_CMP = 3;
   // one-hot register select positions
   localparam int DCF_SEL_CBL = 0;
   localparam int DCF_SEL_CCH = 1;
   localparam int DCF_SEL_CCL = 2;
   localparam int DCF_SEL_FH = 3;
   localparam int DCF_SEL_FL = 4;
   localparam int DCF_SEL_CAX = 5;
   localparam int DCF_NUM_SEL = 6;
   // what a system reset does to the block contents
   typedef enum logic [1:0] {
      DCF_RST_NONE,
      DCF_RST_CLEAR,
      DCF_RST_KEEP
   } dcf_rst_act_t;
endpackage
`default_nettype wire

/* verilog/dcf_cmp_if.sv */
`timescale 1ns/1ps
`default_nettype none
// setup and result of one address comparator
interface dcf_cmp_if;
   logic [15:0] pattern; // expected level per address bit
   logic [15:0] care; // one where the bit takes part
   logic dir_qual; // direction takes part
   logic dir_val; // one matches read, zero write
   logic match; // combinational hit
   modport unit(input pattern, input care, input dir_qual, input dir_val, output match);
   modport owner(output pattern, output care, output dir_qual, output dir_val, input match);
endinterface
`default_nettype wire

/* verilog/dcf_addr_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
module dcf_addr_cmp import dcf_pkg::*; (
   // comparator setup and result
   dcf_cmp_if.unit cmp,
   // cpu cycle under watch
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rw,
   input wire logic cpu_valid
);
   wire logic [15:0] bit_ok; // per bit level agrees or bit ignored
   wire logic addr_ok; // every cared bit agrees
   wire logic dir_ok; // cycle direction acceptable

   // a stored zero wants a low bit, a stored one a high bit
   assign bit_ok = ~(cpu_addr ^ cmp.pattern) | ~cmp.care;
   assign addr_ok = &bit_ok;
   // direction only counts while qualified
   assign dir_ok = ~cmp.dir_qual | (cpu_rw == cmp.dir_val);
   assign cmp.match = cpu_valid & addr_ok & dir_ok;
endmodule // dcf_addr_cmp
`default_nettype wire

/* verilog/dcf_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - reset clears comparator and fifo bytes; an end-run reset keeps them
// - end-trace reset with enable and trace not begun keeps contents
// - comparator b matches address low byte
// - comparator c matches address high byte
// - comparator c matches address low byte
// - fifo high byte zero in event-only
// - fifo low read advances fifo read pointer
// - cax bit7 enables direction match
// - cax bit6 picks read or write
// - cax low bits read zero
// - full modes give comparator b the comparator a direction
module dcf_top import dcf_pkg::*; (
   // clock and power-on reset
   input wire logic mclk,
   input wire logic arst_n,
   // system reset and its kind
   input wire logic sys_reset,
   input wire logic end_run_reset,
   input wire logic end_trace_reset,
   input wire logic debug_unit_enable,
   input wire logic begin_trace_sel,
   // register port
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   // cpu cycle under watch
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rw,
   input wire logic cpu_valid,
   // settings held by neighbouring debug registers
   input wire logic full_mode,
   input wire logic event_only_mode,
   input wire logic [15:0] cmp_a_addr,
   input wire logic [7:0] cmp_b_high_bits,
   input wire logic cmp_b_dir_qualify,
   input wire logic cmp_b_dir_value,
   input wire logic cmp_c_dir_qualify,
   input wire logic cmp_c_dir_value,
   // comparator results
   output logic match_a,
   output logic match_b,
   output logic match_c,
   output logic cmp_a_dir_qualify,
   output logic cmp_a_dir_value,
   // trace capture side
   input wire logic trace_push,
   input wire logic [15:0] trace_word,
   // trace fifo state
   output logic fifo_empty,
   output logic fifo_full,
   output logic [DCF_CNT_W-1:0] fifo_count
);

   // one-hot decode of a bus address, shared by writes and reads
   function automatic logic [DCF_NUM_SEL-1:0] reg_sel(input logic [15:0] addr);
      logic [DCF_NUM_SEL-1:0] sel;
      sel = '0;
      sel[DCF_SEL_CBL] = (addr == DCF_ADDR_CBL);
      sel[DCF_SEL_CCH] = (addr == DCF_ADDR_CCH);
      sel[DCF_SEL_CCL] = (addr == DCF_ADDR_CCL);
      sel[DCF_SEL_FH] = (addr == DCF_ADDR_FH);
      sel[DCF_SEL_FL] = (addr == DCF_ADDR_FL);
      sel[DCF_SEL_CAX] = (addr == DCF_ADDR_CAX);
      return sel;
   endfunction

   // stored comparator bytes
   logic [7:0] cmp_b_low_bits; // comparator b address low byte
   logic [7:0] cmp_c_high_bits; // comparator c address high byte
   logic [7:0] cmp_c_low_bits; // comparator c address low byte
   logic cax_qual; // comparator a direction qualify
   logic cax_val; // comparator a direction value

   // trace fifo storage and pointers
   logic [15:0] fifo_mem [DCF_FIFO_DEPTH]; // captured trace words
   logic [DCF_PTR_W-1:0] wr_ptr; // next slot to fill
   logic [DCF_PTR_W-1:0] rd_ptr; // oldest unread word
   logic [DCF_CNT_W-1:0] count; // words held
   logic [DCF_PTR_W-1:0] next_wr_ptr;
   logic [DCF_PTR_W-1:0] next_rd_ptr;
   logic [DCF_CNT_W-1:0] next_count;

   // reset kind decode
   dcf_rst_act_t rst_act; // what this cycle's system reset does
   wire logic keep_cond; // contents survive the reset
   wire logic clear_now; // contents return to reset values
   wire logic hold_now; // block frozen while cpu sits in reset

   // register port decode
   wire logic [DCF_NUM_SEL-1:0] wr_sel; // write target
   wire logic [DCF_NUM_SEL-1:0] rd_sel; // read target
   wire logic wr_ok; // write may land this cycle
   wire logic [7:0] rd_mux; // read value before the output flop
   wire logic [7:0] cax_rd; // comparator a extension as read

   // fifo control
   wire logic [15:0] head_word; // word under the readout bytes
   wire logic [15:0] push_word; // word as it will be stored
   wire logic push; // store a word this cycle
   wire logic pop; // low byte read with data present
   wire logic drop_oldest; // full fifo overwritten by a push
   wire logic adv_rd; // read pointer moves

   // comparator wiring
   dcf_cmp_if cmp_bus[DCF_NUM_CMP] ();
   wire logic [15:0] cmp_pat [DCF_NUM_CMP]; // expected address per comparator
   wire logic cmp_qual [DCF_NUM_CMP]; // direction qualify per comparator
   wire logic cmp_dval [DCF_NUM_CMP]; // direction value per comparator
   wire logic watch_valid; // cpu cycle watched only while enabled

   // ------------------------------------------------------------
   // reset kind selection
   // ------------------------------------------------------------

   // an end-trace reset with the unit enabled and trace not begun keeps
   // everything; an end-run reset leaves contents undefined, so keeping
   // them is the cheapest legal choice
   assign keep_cond = (end_trace_reset & debug_unit_enable & ~begin_trace_sel)
                      | end_run_reset;
   always_comb begin
      // default: no system reset this cycle
      rst_act = DCF_RST_NONE;
      if (sys_reset) begin
         rst_act = keep_cond ? DCF_RST_KEEP : DCF_RST_CLEAR;
      end
   end
   assign clear_now = (rst_act == DCF_RST_CLEAR);
   assign hold_now = (rst_act != DCF_RST_NONE);

   // ------------------------------------------------------------
   // register port decode
   // ------------------------------------------------------------

   assign wr_sel = reg_sel(bus_addr);
   assign rd_sel = reg_sel(bus_addr);
   // writes are dropped while a system reset is in force
   assign wr_ok = bus_wr & ~hold_now;

   // low six bits of the extension are reserved and read zero
   assign cax_rd = {cax_qual, cax_val, 6'h00};

   // read mux; unmapped addresses read zero
   assign rd_mux = rd_sel[DCF_SEL_CBL] ? cmp_b_low_bits :
                   rd_sel[DCF_SEL_CCH] ? cmp_c_high_bits :
                   rd_sel[DCF_SEL_CCL] ? cmp_c_low_bits :
                   rd_sel[DCF_SEL_FH] ? head_word[15:8] :
                   rd_sel[DCF_SEL_FL] ? head_word[7:0] :
                   rd_sel[DCF_SEL_CAX] ? cax_rd :
                   DCF_RDATA_IDLE;

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata <= DCF_RDATA_IDLE;
      end else begin
         bus_rdata <= bus_rd ? rd_mux : DCF_RDATA_IDLE;
      end
   end

   // ------------------------------------------------------------
   // comparator bytes
   // ------------------------------------------------------------

   // comparator b low byte
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_b_low_bits <= DCF_RST_CBL;
      end else if (clear_now) begin
         cmp_b_low_bits <= DCF_RST_CBL;
      end else if (wr_ok && wr_sel[DCF_SEL_CBL]) begin
         cmp_b_low_bits <= bus_wdata;
      end
   end

   // comparator c high byte
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_c_high_bits <= DCF_RST_CCH;
      end else if (clear_now) begin
         cmp_c_high_bits <= DCF_RST_CCH;
      end else if (wr_ok && wr_sel[DCF_SEL_CCH]) begin
         cmp_c_high_bits <= bus_wdata;
      end
   end

   // comparator c low byte
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_c_low_bits <= DCF_RST_CCL;
      end else if (clear_now) begin
         cmp_c_low_bits <= DCF_RST_CCL;
      end else if (wr_ok && wr_sel[DCF_SEL_CCL]) begin
         cmp_c_low_bits <= bus_wdata;
      end
   end

   // comparator a extension: only the two direction bits are stored
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cax_qual <= DCF_RST_CAX[DCF_CAX_QUAL_BIT];
         cax_val <= DCF_RST_CAX[DCF_CAX_VAL_BIT];
      end else if (clear_now) begin
         cax_qual <= DCF_RST_CAX[DCF_CAX_QUAL_BIT];
         cax_val <= DCF_RST_CAX[DCF_CAX_VAL_BIT];
      end else if (wr_ok && wr_sel[DCF_SEL_CAX]) begin
         cax_qual <= bus_wdata[DCF_CAX_QUAL_BIT];
         cax_val <= bus_wdata[DCF_CAX_VAL_BIT];
      end
   end

   // direction bits handed to the trigger logic
   assign cmp_a_dir_qualify = cax_qual;
   assign cmp_a_dir_value = cax_val;

   // ------------------------------------------------------------
   // comparators
   // ------------------------------------------------------------

   // comparators sleep while the debug unit is off, so no stale hit
   // can reach the trigger logic
   assign watch_valid = cpu_valid & debug_unit_enable & ~hold_now;

   // expected address of each comparator
   assign cmp_pat[DCF_CMP_A] = cmp_a_addr;
   assign cmp_pat[DCF_CMP_B] = {cmp_b_high_bits, cmp_b_low_bits};
   assign cmp_pat[DCF_CMP_C] = {cmp_c_high_bits, cmp_c_low_bits};

   // comparator a direction from its own extension
   assign cmp_qual[DCF_CMP_A] = cax_qual;
   assign cmp_dval[DCF_CMP_A] = cax_val;
   // in full modes comparator b borrows a's direction bits
   assign cmp_qual[DCF_CMP_B] = full_mode ? cax_qual : cmp_b_dir_qualify;
   assign cmp_dval[DCF_CMP_B] = full_mode ? cax_val : cmp_b_dir_value;
   // comparator c keeps its own direction bits
   assign cmp_qual[DCF_CMP_C] = cmp_c_dir_qualify;
   assign cmp_dval[DCF_CMP_C] = cmp_c_dir_value;

   // one comparator unit per address comparator
   generate
      for (genvar gi = 0; gi < DCF_NUM_CMP; gi++) begin : g_cmp
         assign cmp_bus[gi].pattern = cmp_pat[gi];
         // every address bit takes part in the match
         assign cmp_bus[gi].care = 16'hFFFF;
         assign cmp_bus[gi].dir_qual = cmp_qual[gi];
         assign cmp_bus[gi].dir_val = cmp_dval[gi];
         dcf_addr_cmp u_cmp (
            .cmp(cmp_bus[gi]),
            .cpu_addr(cpu_addr),
            .cpu_rw(cpu_rw),
            .cpu_valid(watch_valid)
         );
      end
   endgenerate

   // hits are registered so the trigger logic sees clean levels,
   // at the cost of one cycle of latency
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         match_a <= 1'b0;
         match_b <= 1'b0;
         match_c <= 1'b0;
      end else begin
         match_a <= cmp_bus[DCF_CMP_A].match;
         match_b <= cmp_bus[DCF_CMP_B].match;
         match_c <= cmp_bus[DCF_CMP_C].match;
      end
   end

   // ------------------------------------------------------------
   // trace fifo
   // ------------------------------------------------------------

   assign fifo_empty = (count == '0);
   assign fifo_full = (count == DCF_FIFO_FULL_CNT);
   assign fifo_count = count;
   assign head_word = fifo_mem[rd_ptr];

   // event-only words carry nothing in the high byte
   assign push_word = event_only_mode ? {8'h00, trace_word[7:0]} : trace_word;
   assign push = trace_push & ~hold_now;
   // only the low byte read pops the fifo; an empty fifo stays put
   assign pop = bus_rd & rd_sel[DCF_SEL_FL] & ~fifo_empty & ~hold_now;
   // a full fifo keeps the newest words by dropping the oldest
   assign drop_oldest = push & fifo_full & ~pop;
   assign adv_rd = pop | drop_oldest;

   // pointer and count arithmetic
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_wr_ptr = wr_ptr + 3'h1;
      end
      if (adv_rd) begin
         next_rd_ptr = rd_ptr + 3'h1;
      end
      // count changes only when exactly one side moves
      case ({push, adv_rd})
         2'b10: next_count = count + 4'h1;
         2'b01: next_count = count - 4'h1;
         default: next_count = count;
      endcase
   end

   // pointer registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (clear_now) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // word storage; cleared so an unread slot reads zero after reset
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < DCF_FIFO_DEPTH; i++) begin
            fifo_mem[i] <= DCF_RST_WORD;
         end
      end else if (clear_now) begin
         for (int i = 0; i < DCF_FIFO_DEPTH; i++) begin
            fifo_mem[i] <= DCF_RST_WORD;
         end
      end else if (push) begin
         fifo_mem[wr_ptr] <= push_word;
      end
   end

   // software reads the high byte first; the low byte read retires the
   // word, so a later high byte read shows the next word instead

endmodule // dcf_top
`default_nettype wire

/* dv/dcf_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checker for the comparator and trace readout block
module dcf_top_props import dcf_pkg::*; (
   // clock and reset kinds
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic sys_reset,
   input wire logic end_run_reset,
   input wire logic end_trace_reset,
   input wire logic debug_unit_enable,
   input wire logic begin_trace_sel,
   // register port
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   // watched cycle and results
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_rw,
   input wire logic cpu_valid,
   input wire logic [15:0] cmp_a_addr,
   input wire logic match_a,
   input wire logic match_b,
   input wire logic match_c,
   input wire logic cmp_a_dir_qualify,
   input wire logic cmp_a_dir_value,
   // trace fifo
   input wire logic trace_push,
   input wire logic fifo_empty,
   input wire logic [DCF_CNT_W-1:0] fifo_count
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // reset that must leave contents alone
   wire trace_keep = sys_reset && end_trace_reset && debug_unit_enable && !begin_trace_sel;
   // end-run kind is left out: its contents are undefined
   wire clr_rst = sys_reset && !end_run_reset && !trace_keep;
   wire watch = cpu_valid && debug_unit_enable && !sys_reset;
   wire dir_ok = !cmp_a_dir_qualify || (cpu_rw == cmp_a_dir_value);
   wire rd_cax = bus_rd && bus_addr == DCF_ADDR_CAX;
   // push excluded, it moves the count the other way
   wire pop = bus_rd && bus_addr == DCF_ADDR_FL && !trace_push && !sys_reset;
   AST_RDATA_IDLE: assert property (!bus_rd |=> bus_rdata == DCF_RDATA_IDLE) else $error("read data not idle");
   AST_CAX_RSVD: assert property (rd_cax |=> bus_rdata[5:0] == 6'h00) else $error("reserved bits set");
   AST_CAX_READ: assert property (rd_cax |=> bus_rdata[7] == $past(cmp_a_dir_qualify)
      && bus_rdata[6] == $past(cmp_a_dir_value)) else $error("direction bits misread");
   AST_CAX_WRITE: assert property (bus_wr && bus_addr == DCF_ADDR_CAX && !sys_reset
      |=> {cmp_a_dir_qualify, cmp_a_dir_value} == $past(bus_wdata[7:6])) else $error("direction bits not written");
   AST_FH_NO_POP: assert property (bus_rd && bus_addr == DCF_ADDR_FH && !trace_push && !sys_reset
      |=> $stable(fifo_count)) else $error("high byte read moved fifo");
   AST_FL_POP: assert property (pop && !fifo_empty |=> fifo_count == $past(fifo_count) - 4'h1)
      else $error("low byte read did not pop");
   AST_MATCH_A: assert property (watch && cpu_addr == cmp_a_addr && dir_ok |=> match_a)
      else $error("comparator a missed");
   AST_DIR_MISS: assert property (watch && cmp_a_dir_qualify && cpu_rw != cmp_a_dir_value |=> !match_a)
      else $error("comparator a ignored direction");
   AST_NO_WATCH: assert property (!watch |=> !match_a && !match_b && !match_c) else $error("match without cycle");
   AST_CLEAR: assert property (clr_rst |=> fifo_empty && !cmp_a_dir_qualify && !cmp_a_dir_value)
      else $error("reset did not clear");
   AST_KEEP: assert property (trace_keep |=> $stable(fifo_count) && $stable(cmp_a_dir_qualify)
      && $stable(cmp_a_dir_value)) else $error("end-trace reset lost contents");
   // main scenarios reached
   cover property (pop && !fifo_empty);
   cover property (trace_keep);
   cover property (match_c);
   cover property (fifo_count == DCF_FIFO_FULL_CNT);
endmodule // dcf_top_props
bind dcf_top dcf_top_props u_props (.mclk(mclk), .arst_n(arst_n), .sys_reset(sys_reset),
   .end_run_reset(end_run_reset), .end_trace_reset(end_trace_reset), .debug_unit_enable(debug_unit_enable),
   .begin_trace_sel(begin_trace_sel), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_addr(cpu_addr), .cpu_rw(cpu_rw), .cpu_valid(cpu_valid),
   .cmp_a_addr(cmp_a_addr), .match_a(match_a), .match_b(match_b), .match_c(match_c),
   .cmp_a_dir_qualify(cmp_a_dir_qualify), .cmp_a_dir_value(cmp_a_dir_value), .trace_push(trace_push),
   .fifo_empty(fifo_empty), .fifo_count(fifo_count));
`default_nettype wire

/* dv/dcf_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// cpu address bus seen by the comparators
module dcf_cpu_model (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // cycle request from the bench
   input wire logic req,
   input wire logic [15:0] req_addr,
   input wire logic req_rw,
   // watched bus
   output logic [15:0] cpu_addr,
   output logic cpu_rw,
   output logic cpu_valid
);
   // one qualified cycle per request; idle bus keeps toggling so stale values never pass as a hit
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_addr <= 16'h0000;
         cpu_rw <= 1'b0;
         cpu_valid <= 1'b0;
      end else if (req) begin
         cpu_addr <= req_addr;
         cpu_rw <= req_rw;
         cpu_valid <= 1'b1;
      end else begin
         cpu_addr <= ~cpu_addr;
         cpu_rw <= ~cpu_rw;
         cpu_valid <= 1'b0;
      end
   end
endmodule // dcf_cpu_model
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import dcf_pkg::*;;
   logic mclk = 1'b0, arst_n = 1'b0, sys_reset = 1'b0, end_run_reset = 1'b0, end_trace_reset = 1'b0;
   logic debug_unit_enable = 1'b0, begin_trace_sel = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, full_mode = 1'b0;
   logic [15:0] bus_addr = 16'h0000, cmp_a_addr = 16'h0000, trace_word = 16'h0000, req_addr = 16'h0000;
   logic [7:0] bus_wdata = 8'h00, cmp_b_high_bits = 8'h00, bus_rdata;
   logic event_only_mode = 1'b0, trace_push = 1'b0, req = 1'b0, req_rw = 1'b0;
   logic cmp_b_dir_qualify = 1'b0, cmp_b_dir_value = 1'b0, cmp_c_dir_qualify = 1'b0, cmp_c_dir_value = 1'b0;
   logic [15:0] cpu_addr;
   logic cpu_rw, cpu_valid, match_a, match_b, match_c, aq, av, fifo_empty, fifo_full, rd_d = 1'b0, cv_d = 1'b0;
   logic [DCF_CNT_W-1:0] fifo_count;
   // shadow of the writable bytes and the stored words
   logic [7:0] cbl = 8'h00, cch = 8'h00, ccl = 8'h00, cax = 8'h00;
   logic [7:0] exp_rd[$];
   logic [2:0] exp_mt[$];
   logic [15:0] fq[$];
   int num_errors = 0, n_checks = 0, cycles = 0;
   dcf_top dut (.mclk(mclk), .arst_n(arst_n), .sys_reset(sys_reset), .end_run_reset(end_run_reset),
      .end_trace_reset(end_trace_reset), .debug_unit_enable(debug_unit_enable), .begin_trace_sel(begin_trace_sel),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .cpu_addr(cpu_addr), .cpu_rw(cpu_rw), .cpu_valid(cpu_valid), .full_mode(full_mode),
      .event_only_mode(event_only_mode), .cmp_a_addr(cmp_a_addr), .cmp_b_high_bits(cmp_b_high_bits),
      .cmp_b_dir_qualify(cmp_b_dir_qualify), .cmp_b_dir_value(cmp_b_dir_value), .cmp_c_dir_qualify(cmp_c_dir_qualify),
      .cmp_c_dir_value(cmp_c_dir_value), .match_a(match_a), .match_b(match_b), .match_c(match_c),
      .cmp_a_dir_qualify(aq), .cmp_a_dir_value(av), .trace_push(trace_push), .trace_word(trace_word),
      .fifo_empty(fifo_empty), .fifo_full(fifo_full), .fifo_count(fifo_count));
   dcf_cpu_model u_cpu (.mclk(mclk), .arst_n(arst_n), .req(req), .req_addr(req_addr), .req_rw(req_rw),
      .cpu_addr(cpu_addr), .cpu_rw(cpu_rw), .cpu_valid(cpu_valid));
   // 40 MHz clock
   always #12.5 mclk = ~mclk;
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // expected hits from the stored patterns and direction settings
   function automatic logic [2:0] exp_m(input logic [15:0] a, input logic rw);
      logic da, db, dc;
      da = !cax[7] || rw == cax[6];
      db = full_mode ? da : (!cmp_b_dir_qualify || rw == cmp_b_dir_value);
      dc = !cmp_c_dir_qualify || rw == cmp_c_dir_value;
      return {a == cmp_a_addr && da, a == {cmp_b_high_bits, cbl} && db, a == {cch, ccl} && dc};
   endfunction
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      case (a)
         DCF_ADDR_CBL: cbl = d;
         DCF_ADDR_CCH: cch = d;
         DCF_ADDR_CCL: ccl = d;
         DCF_ADDR_CAX: cax = d;
         default: ;
      endcase
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge mclk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      exp_rd.push_back(e);
      @(posedge mclk);
      bus_rd <= 1'b0;
   endtask
   // extra edge so settings are not changed under the sampled cycle
   task automatic cyc(input logic [15:0] a, input logic rw);
      exp_mt.push_back(exp_m(a, rw));
      @(posedge mclk);
      req <= 1'b1;
      req_addr <= a;
      req_rw <= rw;
      @(posedge mclk);
      req <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic push(input logic [15:0] w, input logic eo);
      @(posedge mclk);
      trace_push <= 1'b1;
      trace_word <= w;
      event_only_mode <= eo;
      fq.push_back(eo ? {8'h00, w[7:0]} : w);
      @(posedge mclk);
      trace_push <= 1'b0;
      trace_word <= ~w;
   endtask
   task automatic srst(input logic keep);
      @(posedge mclk);
      sys_reset <= 1'b1;
      end_trace_reset <= keep | 1'($urandom);
      begin_trace_sel <= !keep;
      @(posedge mclk);
      sys_reset <= 1'b0;
      end_trace_reset <= 1'b0;
      begin_trace_sel <= 1'b0;
      if (!keep) {cbl, cch, ccl, cax} = 32'h00000000;
      if (!keep) fq.delete();
   endtask
   task automatic rd_regs();
      rd(DCF_ADDR_CBL, cbl);
      rd(DCF_ADDR_CCH, cch);
      rd(DCF_ADDR_CCL, ccl);
      rd(DCF_ADDR_CAX, {cax[7:6], 6'h00});
      rd(DCF_ADDR_FH, fq.size() ? fq[0][15:8] : 8'h00);
   endtask
   // result watcher: takes the oldest note whenever read data or the match flags of a watched cycle are due
   always @(posedge mclk) begin
      rd_d <= bus_rd;
      cv_d <= cpu_valid;
   end
   always @(negedge mclk) begin
      if (rd_d) chk(bus_rdata, exp_rd.pop_front());
      if (cv_d) chk({5'h00, match_a, match_b, match_c}, {5'h00, exp_mt.pop_front()});
   end
   initial begin
      void'($urandom(68527));
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      debug_unit_enable <= 1'b1;
      cmp_a_addr <= 16'($urandom);
      cmp_b_high_bits <= 8'($urandom);
      {cmp_c_dir_qualify, cmp_c_dir_value} <= 2'($urandom);
      rd_regs();
      rd(DCF_ADDR_FL, 8'h00);
      rd(16'h3019, 8'h00);
      wr(DCF_ADDR_CBL, 8'($urandom));
      wr(DCF_ADDR_CCH, 8'($urandom));
      wr(DCF_ADDR_CCL, 8'($urandom));
      wr(DCF_ADDR_CAX, 8'($urandom));
      wr(DCF_ADDR_FH, 8'hFF);
      wr(DCF_ADDR_FL, 8'hFF);
      rd_regs();
      // single-bit misses on every address bit
      for (int i = 0; i < 16; i++) cyc({cch, ccl} ^ (16'h0001 << i), 1'($urandom));
      cyc({cch, ccl}, 1'b1);
      cyc({cch, ccl}, 1'b0);
      cyc({cmp_b_high_bits, cbl}, 1'($urandom));
      // every qualify, value and direction, with and without full mode
      for (int i = 0; i < 16; i++) begin
         full_mode <= i[3];
         {cmp_b_dir_qualify, cmp_b_dir_value} <= 2'($urandom);
         cmp_b_high_bits <= cmp_a_addr[15:8];
         wr(DCF_ADDR_CBL, cmp_a_addr[7:0]);
         wr(DCF_ADDR_CAX, {i[2:1], 6'h15});
         cyc(cmp_a_addr, i[0]);
      end
      for (int i = 0; i < 4; i++) push(16'($urandom), i[0]);
      // high byte twice, then low byte, for each of the first three words
      for (int i = 0; i < 3; i++) begin
         rd(DCF_ADDR_FH, fq[0][15:8]);
         rd(DCF_ADDR_FH, fq[0][15:8]);
         rd(DCF_ADDR_FL, 8'(fq.pop_front()));
      end
      push(16'($urandom), 1'b0);
      srst(1'b1);
      rd_regs();
      rd(DCF_ADDR_FL, 8'(fq.pop_front()));
      srst(1'b0);
      rd_regs();
      rd(DCF_ADDR_FL, 8'h00);
      // nine words into eight slots: the oldest is dropped
      for (int i = 0; i < 9; i++) push(16'($urandom), 1'b0);
      @(negedge mclk) chk({3'h0, fifo_full, fifo_count}, {3'h0, 1'b1, DCF_FIFO_FULL_CNT});
      void'(fq.pop_front());
      rd(DCF_ADDR_FH, fq[0][15:8]);
      repeat (3) @(posedge mclk);
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
